// ==== src/cqm_cfg.svh ====
// constant offsets, field positions, reset values and timing counts of the quality monitor
`ifndef CQM_CFG_SVH
`define CQM_CFG_SVH
// ****************************************
// register byte offsets
// ****************************************
`define CQM_ADR_CONFIG 8'h00
`define CQM_ADR_MSE_RESULT 8'h04
`define CQM_ADR_MSE_WORST 8'h08
`define CQM_ADR_INDEX_RESULT 8'h0C
`define CQM_ADR_THRESH_BASE 8'h10
`define CQM_ADR_THRESH_LAST 8'h28
// ****************************************
// config register fields and the worst index field position
// ****************************************
`define CQM_CFG_ENABLE_BIT 0
`define CQM_CFG_SQUARE_BIT 1
`define CQM_CFG_GAIN_LSB 2
`define CQM_CFG_SCALE_LSB 6
`define CQM_CFG_PAIR_LSB 10
`define CQM_CFG_CAPTURE_BIT 15
`define CQM_INDEX_WORST_LSB 4
// ****************************************
// reset values
// ****************************************
`define CQM_CFG_RESET 32'h0000_0000
`define CQM_THRESH_RESET 9'h1FF
`define CQM_INDEX_WORST_RESET 3'h7
// ****************************************
// slicer levels, thresholds and error bounds
// ****************************************
`define CQM_LEVEL_OUTER 10'sd128
`define CQM_LEVEL_INNER 10'sd64
`define CQM_THR_GIG_OUTER 10'sd96
`define CQM_THR_GIG_INNER 10'sd32
`define CQM_THR_FAST 10'sd64
`define CQM_ERR_BOUND_GIG 11'd32
`define CQM_ERR_BOUND_FAST 11'd64
`define CQM_MSE_MAX 9'h1FF
// ****************************************
// snapshot period
// ****************************************
`define CQM_SNAP_TIME_US 1000
`define CQM_SYMBOL_RATE_MHZ 125
`define CQM_SNAP_SYMBOLS (`CQM_SNAP_TIME_US * `CQM_SYMBOL_RATE_MHZ)
`endif

// ==== src/cqm_pkg.sv ====
// shared types of the quality monitor
`default_nettype none
package cqm_pkg;
    typedef logic signed [9:0] sample_t;
    // per-symbol receive samples for the four cable pairs
    typedef struct packed {
        logic valid;
        logic gbps;
        sample_t [3:0] lane;
    } sym_bus_t;
    // software controls steering the filters
    typedef struct packed {
        logic enable;
        logic square_sel;
        logic [3:0] filter_gain_shift;
        logic [3:0] error_scale_shift;
        logic [1:0] cable_pair_select;
    } cfg_t;
    // bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;
endpackage
`default_nettype wire

// ==== src/pair_filter.sv ====
// slicer, error shaping, low-pass filter and millisecond snapshot for one cable pair
`timescale 1ns/1ns
`default_nettype none
`include "cqm_cfg.svh"
module pair_filter
    import cqm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sym_valid,
    input wire logic gbps,
    input wire sample_t sample,
    input wire cfg_t cfg,
    input wire logic snap,
    output logic [8:0] mse_ff
);
    logic signed [10:0] level;
    logic signed [10:0] err;
    logic [10:0] err_abs;
    logic [10:0] err_bound;
    logic [6:0] err_clip;
    logic [6:0] err_scaled;
    logic [12:0] err_proc;
    logic [20:0] state_ff;
    logic signed [21:0] diff;
    logic signed [21:0] step;
    logic [20:0] nxt_state;
    logic [12:0] filt_int;
    logic [12:0] filt_scaled;
    logic [8:0] nxt_mse;

    // decide the symbol against the compare thresholds
    assign level = gbps ?
        ((sample < -`CQM_THR_GIG_OUTER) ? -11'(`CQM_LEVEL_OUTER) :
         (sample < -`CQM_THR_GIG_INNER) ? -11'(`CQM_LEVEL_INNER) :
         (sample <= `CQM_THR_GIG_INNER) ? 11'sd0 :
         (sample <= `CQM_THR_GIG_OUTER) ? 11'(`CQM_LEVEL_INNER) :
         11'(`CQM_LEVEL_OUTER)) :
        ((sample < -`CQM_THR_FAST) ? -11'(`CQM_LEVEL_OUTER) :
         (sample <= `CQM_THR_FAST) ? 11'sd0 :
         11'(`CQM_LEVEL_OUTER));

    // distance from the ideal level, clipped to the speed's bound
    assign err = 11'(sample) - level;
    assign err_abs = err[10] ? 11'(-err) : 11'(err);
    assign err_bound = gbps ? `CQM_ERR_BOUND_GIG : `CQM_ERR_BOUND_FAST;
    assign err_clip = (err_abs > err_bound) ? err_bound[6:0] : err_abs[6:0];

    // doubling at gigabit, then optional squaring
    assign err_scaled = gbps ? {err_clip[5:0], 1'b0} : err_clip;
    assign err_proc = cfg.square_sel ? 13'(err_scaled * err_scaled) : 13'(err_scaled);

    // first-order low-pass, eight fraction bits keep small steps alive
    assign diff = $signed({1'b0, err_proc, 8'h00}) - $signed({1'b0, state_ff});
    assign step = diff >>> cfg.filter_gain_shift;
    assign nxt_state = 21'($signed({1'b0, state_ff}) + step);

    // scale the integer part into 0..511 with saturation
    assign filt_int = state_ff[20:8];
    assign filt_scaled = filt_int >> cfg.error_scale_shift;
    assign nxt_mse = (filt_scaled > 13'(`CQM_MSE_MAX)) ? `CQM_MSE_MAX : filt_scaled[8:0];

    // filter state, held at zero while measurement is off
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= 21'h00_0000;
        end else if (!cfg.enable) begin
            state_ff <= 21'h00_0000;
        end else if (sym_valid) begin
            state_ff <= nxt_state;
        end
    end

    // millisecond snapshot of the scaled figure
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mse_ff <= 9'h000;
        end else if (!cfg.enable) begin
            mse_ff <= 9'h000;
        end else if (snap) begin
            mse_ff <= nxt_mse;
        end
    end
endmodule
`default_nettype wire

// ==== src/channel_quality_monitor.sv ====
// receive channel quality monitor with wishbone register access
`timescale 1ns/1ns
`default_nettype none
`include "cqm_cfg.svh"
module channel_quality_monitor
    import cqm_pkg::*;
#(
    parameter int unsigned SNAP_SYMBOLS = `CQM_SNAP_SYMBOLS
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire sym_bus_t sym_in,
    output logic link_drop_permit
);
    // ****************************************
    // declarations
    // ****************************************
    bus_state_t bus_state_ff;
    bus_state_t nxt_bus_state;
    cfg_t cfg_ff;
    cfg_t cfg_new;
    logic [8:0] thresh_ff [1:7];
    logic [8:0] mse_res_ff;
    logic [8:0] mse_worst_ff;
    logic [2:0] idx_res_ff;
    logic [2:0] idx_worst_ff;
    logic [16:0] sym_cnt_ff;
    logic snap;
    logic snap_d_ff;
    logic [8:0] pair_mse [0:3];
    logic [2:0] pair_idx [0:3];
    logic [3:0] pair_fail;
    logic req;
    logic wr_take;
    logic rd_take;
    logic [31:0] wmask;
    logic [31:0] cfg_img;
    logic [31:0] cfg_wr;
    logic capture;
    logic [1:0] cap_pair;
    logic sel_cfg;
    logic sel_mse;
    logic sel_worst;
    logic sel_idx;
    logic sel_thr;
    logic [2:0] thr_num;
    logic [31:0] rd_mux;
    logic [8:0] sel_mse_now;
    logic [2:0] sel_idx_now;
    logic [8:0] mse_track_base;
    logic [2:0] idx_track_base;
    logic snap_seen_ff;
    logic [8:0] cap_mse;
    logic [2:0] cap_idx;
    logic snap_upd;
    logic [8:0] thr_old;
    logic [8:0] thr_wr;

    // ****************************************
    // quality index mapping
    // ****************************************
    // highest-numbered threshold not exceeded, 0 when above all seven thresholds
    function automatic logic [2:0] to_index(input logic [8:0] mse, input logic [62:0] thr);
        logic [2:0] idx;
        idx = 3'h0;
        for (int k = 1; k <= 7; k++) begin
            if (mse <= thr[9*(k-1) +: 9]) begin
                idx = 3'(k);
            end
        end
        return idx;
    endfunction

    logic [62:0] thr_flat;
    assign thr_flat = {thresh_ff[7], thresh_ff[6], thresh_ff[5], thresh_ff[4],
                       thresh_ff[3], thresh_ff[2], thresh_ff[1]};

    // ****************************************
    // per-pair filters
    // ****************************************
    // symbol counter marks each millisecond boundary
    assign snap = sym_in.valid && (sym_cnt_ff == 17'(SNAP_SYMBOLS - 1));

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sym_cnt_ff <= 17'h0_0000;
        end else if (!cfg_ff.enable || snap) begin
            sym_cnt_ff <= 17'h0_0000;
        end else if (sym_in.valid) begin
            sym_cnt_ff <= sym_cnt_ff + 17'h0_0001;
        end
    end

    // one independent filter per cable pair
    for (genvar p = 0; p < 4; p++) begin : g_pair
        pair_filter u_pair (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .sym_valid(sym_in.valid),
            .gbps(sym_in.gbps),
            .sample(sym_in.lane[p]),
            .cfg(cfg_ff),
            .snap(snap),
            .mse_ff(pair_mse[p])
        );
        assign pair_idx[p] = to_index(pair_mse[p], thr_flat);
        assign pair_fail[p] = (pair_idx[p] == 3'h0);
    end

    // quality drop only permitted at index zero of a valid square-mode measurement
    assign link_drop_permit = cfg_ff.enable && cfg_ff.square_sel && snap_seen_ff
                              && pair_fail[cfg_ff.cable_pair_select];

    // at least one snapshot since enable before a drop may be permitted
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            snap_seen_ff <= 1'b0;
        end else if (!cfg_ff.enable) begin
            snap_seen_ff <= 1'b0;
        end else if (snap) begin
            snap_seen_ff <= 1'b1;
        end
    end

    // ****************************************
    // wishbone slave
    // ****************************************
    // ack one cycle after the request, dropped the cycle after
    assign req = wb_cyc_i && wb_stb_i;
    assign nxt_bus_state = (bus_state_ff == BUS_IDLE && req) ? BUS_ACK : BUS_IDLE;
    assign wb_ack_o = (bus_state_ff == BUS_ACK);
    assign wr_take = wb_ack_o && req && wb_we_i;
    assign rd_take = wb_ack_o && req && !wb_we_i;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_state_ff <= BUS_IDLE;
        end else begin
            case (bus_state_ff)
                BUS_IDLE: bus_state_ff <= nxt_bus_state;
                BUS_ACK: bus_state_ff <= BUS_IDLE;
                default: bus_state_ff <= BUS_IDLE;
            endcase
        end
    end

    // address decode
    assign sel_cfg = (wb_adr_i == `CQM_ADR_CONFIG);
    assign sel_mse = (wb_adr_i == `CQM_ADR_MSE_RESULT);
    assign sel_worst = (wb_adr_i == `CQM_ADR_MSE_WORST);
    assign sel_idx = (wb_adr_i == `CQM_ADR_INDEX_RESULT);
    assign sel_thr = (wb_adr_i >= `CQM_ADR_THRESH_BASE) && (wb_adr_i <= `CQM_ADR_THRESH_LAST)
                     && (wb_adr_i[1:0] == 2'h0);
    assign thr_num = 3'((wb_adr_i - `CQM_ADR_THRESH_BASE) >> 2) + 3'h1;

    // byte lane merge of the config image
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign cfg_img = 32'(cfg_ff.enable) << `CQM_CFG_ENABLE_BIT
                   | 32'(cfg_ff.square_sel) << `CQM_CFG_SQUARE_BIT
                   | 32'(cfg_ff.filter_gain_shift) << `CQM_CFG_GAIN_LSB
                   | 32'(cfg_ff.error_scale_shift) << `CQM_CFG_SCALE_LSB
                   | 32'(cfg_ff.cable_pair_select) << `CQM_CFG_PAIR_LSB;
    assign cfg_wr = (cfg_img & ~wmask) | (wb_dat_i & wmask);
    assign cfg_new.enable = cfg_wr[`CQM_CFG_ENABLE_BIT];
    assign cfg_new.square_sel = cfg_wr[`CQM_CFG_SQUARE_BIT];
    assign cfg_new.filter_gain_shift = cfg_wr[`CQM_CFG_GAIN_LSB +: 4];
    assign cfg_new.error_scale_shift = cfg_wr[`CQM_CFG_SCALE_LSB +: 4];
    assign cfg_new.cable_pair_select = cfg_wr[`CQM_CFG_PAIR_LSB +: 2];

    // capture request rides on a config write, never stored
    assign capture = wr_take && sel_cfg && cfg_wr[`CQM_CFG_CAPTURE_BIT];
    assign cap_pair = cfg_new.cable_pair_select;
    // figure and index of the pair named in the capture write
    assign cap_mse = pair_mse[cap_pair];
    assign cap_idx = pair_idx[cap_pair];

    // read data selection, capture bit always reads zero
    assign rd_mux = sel_cfg ? cfg_img :
                    sel_mse ? 32'(mse_res_ff) :
                    sel_worst ? 32'(mse_worst_ff) :
                    sel_idx ? (32'(idx_res_ff) | (32'(idx_worst_ff) << `CQM_INDEX_WORST_LSB)) :
                    sel_thr ? 32'(thresh_ff[thr_num]) : 32'h0000_0000;

    // registered read data, loaded when a read request is seen in idle, so it is ready with the ack
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && bus_state_ff == BUS_IDLE && !wb_we_i) begin
            wb_dat_o <= rd_mux;
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    // config register, the capture bit is never stored
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ff <= cfg_t'(12'(`CQM_CFG_RESET));
        end else if (wr_take && sel_cfg) begin
            cfg_ff <= cfg_new;
        end
    end

    // byte-lane merge of a threshold write
    assign thr_old = thresh_ff[thr_num];
    assign thr_wr = {wb_sel_i[1] ? wb_dat_i[8] : thr_old[8],
                     wb_sel_i[0] ? wb_dat_i[7:0] : thr_old[7:0]};

    // threshold registers one to seven
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int k = 1; k <= 7; k++) begin
                thresh_ff[k] <= `CQM_THRESH_RESET;
            end
        end else if (wr_take && sel_thr) begin
            thresh_ff[thr_num] <= thr_wr;
        end
    end

    // capture loads figure and index of the chosen pair
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mse_res_ff <= 9'h000;
            idx_res_ff <= 3'h0;
        end else if (capture) begin
            mse_res_ff <= cap_mse;
            idx_res_ff <= cap_idx;
        end
    end

    // ****************************************
    // worst-case trackers
    // ****************************************
    // a fresh snapshot of the selected pair lands one cycle after snap
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            snap_d_ff <= 1'b0;
        end else begin
            snap_d_ff <= snap;
        end
    end

    assign sel_mse_now = pair_mse[cfg_ff.cable_pair_select];
    assign sel_idx_now = pair_idx[cfg_ff.cable_pair_select];
    // a read restarts from the current result; a new value in the same cycle still counts
    assign mse_track_base = (rd_take && sel_mse) ? mse_res_ff : mse_worst_ff;
    assign idx_track_base = (rd_take && sel_idx) ? idx_res_ff : idx_worst_ff;
    // a snapshot counts for the trackers only while measuring
    assign snap_upd = snap_d_ff && cfg_ff.enable;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mse_worst_ff <= 9'h000;
        end else if (capture && cap_mse > mse_track_base) begin
            mse_worst_ff <= cap_mse;
        end else if (snap_upd && sel_mse_now > mse_track_base) begin
            mse_worst_ff <= sel_mse_now;
        end else begin
            mse_worst_ff <= mse_track_base;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            idx_worst_ff <= `CQM_INDEX_WORST_RESET;
        end else if (capture && cap_idx < idx_track_base) begin
            idx_worst_ff <= cap_idx;
        end else if (snap_upd && sel_idx_now < idx_track_base) begin
            idx_worst_ff <= sel_idx_now;
        end else begin
            idx_worst_ff <= idx_track_base;
        end
    end
endmodule
`default_nettype wire

// ==== dv/cqm_properties.sv ====
// concurrent checks of bus timing and register fields of the quality monitor
`timescale 1ns/1ns
`default_nettype none
module cqm_properties (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic link_drop_permit
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // ****************************************
    // decoded bus events
    // ****************************************
    wire req = wb_cyc_i && wb_stb_i;
    wire rd_ack = wb_ack_o && !wb_we_i;
    wire off_ack = wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] && !wb_dat_i[0];
    // ****************************************
    // assertions
    // ****************************************
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_AFTER_REQ: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("ack without a request");
    AST_DAT_HOLD: assert property (!(req && !wb_we_i) |=> $stable(wb_dat_o))
        else $error("read data changed without a read");
    AST_PERMIT_OFF: assert property (off_ack |=> !link_drop_permit)
        else $error("link drop permitted while disabled");
    AST_CAPTURE_CLEAR: assert property (rd_ack && wb_adr_i == 8'h00 |-> !wb_dat_o[15])
        else $error("capture bit reads back set");
    AST_MSE_RANGE: assert property (
        rd_ack && (wb_adr_i == 8'h04 || wb_adr_i == 8'h08) |-> wb_dat_o[31:9] == 23'h0)
        else $error("error figure above 511");
    AST_INDEX_FIELDS: assert property (
        rd_ack && wb_adr_i == 8'h0C |-> wb_dat_o[31:7] == 25'h0 && !wb_dat_o[3])
        else $error("index register reserved bits set");
    AST_THRESH_WIDTH: assert property (
        rd_ack && wb_adr_i >= 8'h10 && wb_adr_i <= 8'h28 |-> wb_dat_o[31:9] == 23'h0)
        else $error("threshold wider than nine bits");
    // main scenarios reached
    cover property (off_ack);
    cover property (rd_ack && wb_adr_i == 8'h0C && wb_dat_o[2:0] == 3'h0);
    cover property ($rose(link_drop_permit));
endmodule
bind channel_quality_monitor cqm_properties u_cqm_properties (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_drop_permit(link_drop_permit)
);
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench of the channel quality monitor
`timescale 1ns/1ns
`default_nettype none
module tb
    import cqm_pkg::*;
;
    localparam int SNAP = 8;
    localparam int SCALE = 3;
    localparam int LIMIT = 5000;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic link_drop_permit;
    sym_bus_t sym_in = '0;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    // thresholds one..seven, then per case lane samples, speed and filter gain
    int th [7] = '{500, 450, 400, 300, 200, 100, 40};
    int smp [3][4] = '{'{10, 200, -40, 33}, '{32, 100, -33, 0}, '{64, 65, -70, -300}};
    logic spd [3] = '{1'b1, 1'b1, 1'b0};
    int gn [3] = '{0, 2, 1};

    // clock of 50 ns period
    always #25 sys_clk = ~sys_clk;

    channel_quality_monitor #(.SNAP_SYMBOLS(SNAP)) u_channel_quality_monitor (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sym_in(sym_in),
        .link_drop_permit(link_drop_permit)
    );

    // slicer error of one sample, squared when sq is set, doubled first at the higher speed
    function automatic int proc_err(input logic g, input int s, input logic sq);
        int lvl;
        int e;
        if (g) begin
            lvl = (s < -96) ? -128 : (s < -32) ? -64 : (s <= 32) ? 0 : (s <= 96) ? 64 : 128;
        end else begin
            lvl = (s < -64) ? -128 : (s <= 64) ? 0 : 128;
        end
        e = (s > lvl) ? s - lvl : lvl - s;
        e = g ? ((e > 32) ? 32 : e) * 2 : ((e > 64) ? 64 : e);
        return sq ? e * e : e;
    endfunction

    // filter state after a run of equal samples, then scaled and capped
    function automatic int expect_mse(input logic g, input int s, input int gain,
                                      input logic sq);
        int st;
        int m;
        st = 0;
        // the snapshot edge stores the state before its own symbol is filtered
        repeat (SNAP - 1) st = st + ((proc_err(g, s, sq) * 256 - st) >>> gain);
        m = (st >>> 8) >>> SCALE;
        return (m > 511) ? 511 : m;
    endfunction

    // highest-numbered threshold not exceeded
    function automatic int index_of(input int m);
        int idx;
        idx = 0;
        for (int k = 1; k <= 7; k++) if (m <= th[k - 1]) idx = k;
        return idx;
    endfunction

    function automatic logic [31:0] cfgw(input int pair, input int gain, input logic cap,
                                         input logic en);
        return {16'h0000, cap, 3'h0, 2'(pair), 4'(SCALE), 4'(gain), en, en};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one classic cycle: hold until ack is sampled, then release for a cycle
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && n < 16) begin
            @(posedge sys_clk);
            n++;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 16) check(32'h0000_0000, 32'h0000_0001, "no ack");
        @(posedge sys_clk);
    endtask

    task automatic rd_check(input logic [7:0] adr, input logic [31:0] exp, input string what);
        logic [31:0] q;
        wb_xfer(1'b0, adr, 32'h0000_0000, q);
        check(q, exp, what);
    endtask

    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles >= LIMIT) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int prev_mse;
        int prev_idx;
        int run_mse;
        int run_idx;
        int m [4];
        logic [31:0] q;
        prev_mse = 0;
        prev_idx = 0;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rd_check(8'h00, 32'h0000_0000, "config reset");
        rd_check(8'h04, 32'h0000_0000, "result reset");
        rd_check(8'h08, 32'h0000_0000, "worst reset");
        rd_check(8'h0C, 32'h0000_0070, "index reset");
        for (int k = 0; k < 7; k++) begin
            rd_check(8'h10 + 8'(4 * k), 32'h0000_01FF, "threshold reset");
            wb_xfer(1'b1, 8'h10 + 8'(4 * k), 32'(th[k]), q);
        end
        wb_sel_i <= 4'h2;
        wb_xfer(1'b1, 8'h10, 32'h0000_0000, q);
        wb_sel_i <= 4'hF;
        rd_check(8'h10, 32'(th[0]) & 32'h0000_00FF, "byte enable");
        wb_xfer(1'b1, 8'h10, 32'(th[0]), q);
        rd_check(8'h28, 32'(th[6]), "threshold seven");
        wb_xfer(1'b1, 8'h40, 32'hFFFF_FFFF, q);
        rd_check(8'h40, 32'h0000_0000, "unmapped");
        for (int c = 0; c < 3; c++) begin
            wb_xfer(1'b1, 8'h00, cfgw(0, gn[c], 1'b0, 1'b0), q);
            check(32'(link_drop_permit), 32'h0000_0000, "permit off");
            rd_check(8'h04, 32'(prev_mse), "result held");
            rd_check(8'h0C, 32'(prev_idx * 17), "index held");
            run_mse = prev_mse;
            run_idx = prev_idx;
            wb_xfer(1'b1, 8'h00, cfgw(0, gn[c], 1'b0, 1'b1), q);
            for (int p = 0; p < 4; p++) begin
                sym_in.lane[p] <= sample_t'(smp[c][p]);
                m[p] = expect_mse(spd[c], smp[c][p], gn[c], 1'b1);
            end
            sym_in.gbps <= spd[c];
            sym_in.valid <= 1'b1;
            repeat (SNAP) @(posedge sys_clk);
            sym_in.valid <= 1'b0;
            repeat (2) @(posedge sys_clk);
            run_mse = (m[0] > run_mse) ? m[0] : run_mse;
            run_idx = (index_of(m[0]) < run_idx) ? index_of(m[0]) : run_idx;
            for (int p = 0; p < 4; p++) begin
                wb_xfer(1'b1, 8'h00, cfgw(p, gn[c], 1'b1, 1'b1), q);
                run_mse = (m[p] > run_mse) ? m[p] : run_mse;
                run_idx = (index_of(m[p]) < run_idx) ? index_of(m[p]) : run_idx;
                rd_check(8'h08, 32'(run_mse), "worst result");
                rd_check(8'h04, 32'(m[p]), "result");
                run_mse = m[p];
            end
            rd_check(8'h0C, 32'(run_idx * 16 + index_of(m[3])), "index");
            check(32'(link_drop_permit), 32'(index_of(m[3]) == 0), "permit");
            rd_check(8'h00, cfgw(3, gn[c], 1'b0, 1'b1), "capture cleared");
            prev_mse = m[3];
            prev_idx = index_of(m[3]);
        end
        // linear error without squaring; pair three still holds index zero
        wb_xfer(1'b1, 8'h00, cfgw(3, 0, 1'b0, 1'b1) & 32'hFFFF_FFFD, q);
        check(32'(link_drop_permit), 32'h0000_0000, "permit linear");
        sym_in.valid <= 1'b1;
        repeat (SNAP) @(posedge sys_clk);
        sym_in.valid <= 1'b0;
        repeat (2) @(posedge sys_clk);
        wb_xfer(1'b1, 8'h00, cfgw(3, 0, 1'b1, 1'b1) & 32'hFFFF_FFFD, q);
        rd_check(8'h04, 32'(expect_mse(1'b0, smp[2][3], 0, 1'b0)), "linear result");
        tally_and_finish();
    end
endmodule
`default_nettype wire
